// ---- core/offset_cal_pkg.sv ----
// constants for the offset calibration control block
package offset_cal_pkg;
    localparam int          DATA_W          = 16;
    localparam int          CMD_W           = 3;
    // parameter addresses as seen on the parameter port
    localparam logic [15:0] ADDR_CAL_CMD    = 16'h0414;
    localparam logic [15:0] ADDR_SPEED_ONE  = 16'h0416;
    localparam logic [15:0] ADDR_SPEED_TWO  = 16'h0418;
    localparam logic [15:0] ADDR_TORQUE_ONE = 16'h041A;
    localparam logic [15:0] ADDR_TORQUE_TWO = 16'h041C;
    // command codes
    localparam logic [2:0]  CMD_IDLE        = 3'h0;
    localparam logic [2:0]  CMD_SPEED       = 3'h1;
    localparam logic [2:0]  CMD_TORQUE      = 3'h2;
    localparam logic [2:0]  CMD_PHASE_V     = 3'h3;
    localparam logic [2:0]  CMD_PHASE_W     = 3'h4;
    localparam logic [2:0]  CMD_ALL_HW      = 3'h5;
    localparam logic [2:0]  CMD_IGBT_ADC    = 3'h6;
    localparam logic [15:0] CMD_MAX         = 16'h0006;
    // value limits, values after reset and the value read at unmapped addresses
    localparam logic [15:0] OFFSET_MAX      = 16'h7FFF;
    localparam logic [15:0] CMD_RESET       = 16'h0000;
    localparam logic [15:0] OFFSET_RESET    = 16'h0000;
    localparam logic [15:0] READ_UNMAPPED   = 16'h0000;
endpackage : offset_cal_pkg

// ---- core/cal_if.sv ----
// carrier between the register side and the calibration sequencer
`timescale 1ns/10ps
interface cal_if;
    logic        start;     // accepted command, one-cycle pulse
    logic [2:0]  cmd;       // command code with start
    logic        busy;      // sequencer running
    logic        done;      // last result written, pulse
    logic        wrValid;   // result ready, pulse
    logic [2:0]  wrTarget;  // code of the measured item
    logic [15:0] wrValue;   // measured offset

    modport regs (output start, cmd, input busy, done, wrValid, wrTarget, wrValue);
    modport engine (input start, cmd, output busy, done, wrValid, wrTarget, wrValue);
endinterface : cal_if

// ---- core/offset_sequencer.sv ----
// sequencer that measures offsets one target at a time
`timescale 1ns/10ps
module offset_sequencer (
    input  wire logic        sys_clk,     // 50 MHz clock
    input  wire logic        sys_rst,     // async reset, active high
    cal_if.engine            cal,         // command and result carrier
    output logic             adcReq,      // sample request, held until ack
    output logic [2:0]       adcChannel,  // item being sampled
    input  wire logic        adcAck,      // sample ready
    input  wire logic [15:0] adcData      // raw sample
);
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_REQ   = 2'b01,
        SEQ_WRITE = 2'b10
    } seq_state_t;

    typedef struct packed {
        seq_state_t  state;
        logic [2:0]  cur;
        logic [2:0]  last;
        logic [15:0] value;
    } seq_t;

    seq_t s_q;
    seq_t s_d;

    // clamp raw sample into the offset range
    function automatic logic [15:0] clampOffset(input logic [15:0] raw);
        clampOffset = (raw > offset_cal_pkg::OFFSET_MAX) ? offset_cal_pkg::OFFSET_MAX : raw;
    endfunction : clampOffset

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        s_d = s_q;
        case (s_q.state)
            SEQ_IDLE:
            begin
                if (cal.start)
                begin
                    // combined run walks codes one to four
                    if (cal.cmd == offset_cal_pkg::CMD_ALL_HW) // R4
                    begin
                        s_d.cur  = offset_cal_pkg::CMD_SPEED;
                        s_d.last = offset_cal_pkg::CMD_PHASE_W;
                    end
                    else // R1 R3 R5
                    begin
                        s_d.cur  = cal.cmd;
                        s_d.last = cal.cmd;
                    end
                    s_d.state = SEQ_REQ;
                end
            end
            SEQ_REQ:
            begin
                if (adcAck)
                begin
                    s_d.value = clampOffset(adcData); // R8
                    s_d.state = SEQ_WRITE;
                end
            end
            SEQ_WRITE:
            begin
                if (s_q.cur == s_q.last)
                    s_d.state = SEQ_IDLE;
                else
                begin
                    s_d.cur   = s_q.cur + 3'h1; // R4
                    s_d.state = SEQ_REQ;
                end
            end
            default:
                s_d.state = SEQ_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
            s_q <= '{SEQ_IDLE, 3'h0, 3'h0, 16'h0000};
        else
            s_q <= s_d;
    end

    // outputs
    assign adcReq       = (s_q.state == SEQ_REQ);
    assign adcChannel   = s_q.cur;
    assign cal.busy     = (s_q.state != SEQ_IDLE);
    assign cal.wrValid  = (s_q.state == SEQ_WRITE);
    assign cal.wrTarget = s_q.cur;
    assign cal.wrValue  = s_q.value;
    assign cal.done     = (s_q.state == SEQ_WRITE) && (s_q.cur == s_q.last); // R11

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_all_hw_first;
        @(posedge sys_clk) disable iff (sys_rst)
        cal.start && !cal.busy && cal.cmd == offset_cal_pkg::CMD_ALL_HW
            |=> adcReq && adcChannel == offset_cal_pkg::CMD_SPEED;
    endproperty
    a_all_hw_first: assert property (p_all_hw_first) else $error("combined run not at code 1"); // R4

    property p_single_target;
        @(posedge sys_clk) disable iff (sys_rst)
        cal.start && !cal.busy && cal.cmd != offset_cal_pkg::CMD_ALL_HW
            |=> adcReq && adcChannel == $past(cal.cmd);
    endproperty
    a_single_target: assert property (p_single_target) else $error("wrong item sampled"); // R3

    property p_req_holds;
        @(posedge sys_clk) disable iff (sys_rst)
        adcReq && !adcAck |=> adcReq && $stable(adcChannel);
    endproperty
    a_req_holds: assert property (p_req_holds) else $error("request dropped early"); // R5

    property p_ack_writes;
        @(posedge sys_clk) disable iff (sys_rst)
        adcReq && adcAck |=> cal.wrValid ##1 !cal.wrValid;
    endproperty
    a_ack_writes: assert property (p_ack_writes) else $error("result not one pulse"); // R11

    c_all_hw: cover property (@(posedge sys_clk) cal.done && adcChannel == 3'h4);
endmodule : offset_sequencer

// ---- core/offset_calibration_control.sv ----
// offset calibration command and offset parameter registers
`timescale 1ns/10ps
// Functional notes
// R1: command 1 calibrates speed input offset, command 2 the torque input offset.
// R2: command 0 starts nothing; only values zero to six are accepted (the code refuses a write of zero as well).
// R3: commands 3 and 4 calibrate V and W phase current detector offsets.
// R4: command 5 runs hardware adjustments one to four as one operation.
// R5: command 6 calibrates the power-stage temperature converter.
// R6: commands and offset writes act only while calibration enable is set.
// R7: host keeps the output stage off during any calibration.
// R8: each offset holds 0 to 32767 and may be written by hand.
// R9: restoring defaults leaves all four offset registers unchanged.
// R10: host should avoid writing the second speed and torque offsets.
// R11: on completion the result is stored and the command returns to zero.
module offset_calibration_control (
    input  wire logic        sys_clk,         // 50 MHz clock
    input  wire logic        sys_rst,         // async reset, active high
    input  wire logic        parWrite,        // parameter write strobe
    input  wire logic        parRead,         // parameter read strobe
    input  wire logic [15:0] parAddr,         // parameter address
    input  wire logic [15:0] parWrData,       // write data
    output logic [15:0]      parRdData,       // read data, one cycle after strobe
    output logic             parRefused,      // write refused, pulse
    input  wire logic        calEnable,       // calibration enable parameter
    input  wire logic        restoreDefaults, // restore-defaults pulse
    output logic             adcReq,          // sample request
    output logic [2:0]       adcChannel,      // item being sampled
    input  wire logic        adcAck,          // sample ready
    input  wire logic [15:0] adcData,         // raw sample
    output logic             calBusy,         // calibration running
    output logic             hwResultValid,   // result for an item outside this map
    output logic [2:0]       hwResultTarget,  // code 3, 4 or 6
    output logic [15:0]      hwResultData     // result value
);
    typedef struct packed {
        logic [15:0] cmd;
        logic [15:0] speedOne;
        logic [15:0] speedTwo;
        logic [15:0] torqueOne;
        logic [15:0] torqueTwo;
        logic [15:0] rdData;
        logic        refused;
        logic        hwValid;
        logic [2:0]  hwTarget;
        logic [15:0] hwData;
    } regs_t;

    regs_t r_q;
    regs_t r_d;
    cal_if cal ();

    logic  wrCmd;
    logic  wrOffset;
    logic  cmdOk;
    logic  offOk;

    offset_sequencer u_seq (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .cal        (cal),
        .adcReq     (adcReq),
        .adcChannel (adcChannel),
        .adcAck     (adcAck),
        .adcData    (adcData)
    );

    // offset address decode, used for writes only
    function automatic logic isOffsetAddr(input logic [15:0] a);
        isOffsetAddr = (a == offset_cal_pkg::ADDR_SPEED_ONE)
                    || (a == offset_cal_pkg::ADDR_SPEED_TWO)
                    || (a == offset_cal_pkg::ADDR_TORQUE_ONE)
                    || (a == offset_cal_pkg::ADDR_TORQUE_TWO);
    endfunction : isOffsetAddr

    ////////////////////////////////////////////////////////////////////////
    // write qualification
    assign wrCmd    = parWrite && (parAddr == offset_cal_pkg::ADDR_CAL_CMD);
    assign wrOffset = parWrite && isOffsetAddr(parAddr);
    assign cmdOk    = calEnable && !cal.busy && (parWrData <= offset_cal_pkg::CMD_MAX)
                   && (parWrData != offset_cal_pkg::CMD_RESET); // R2 R6
    assign offOk    = calEnable && (parWrData <= offset_cal_pkg::OFFSET_MAX); // R6 R8
    assign cal.start = wrCmd && cmdOk; // R1
    assign cal.cmd   = parWrData[2:0];

    // register update
    always_comb
    begin
        r_d         = r_q;
        r_d.refused = (wrCmd && !cmdOk) || (wrOffset && !offOk);
        r_d.hwValid = 1'b0;
        if (cal.start)
            r_d.cmd = parWrData;
        if (wrOffset && offOk) // R8
        begin
            case (parAddr)
                offset_cal_pkg::ADDR_SPEED_ONE:  r_d.speedOne  = parWrData;
                offset_cal_pkg::ADDR_SPEED_TWO:  r_d.speedTwo  = parWrData;
                offset_cal_pkg::ADDR_TORQUE_ONE: r_d.torqueOne = parWrData;
                default:                         r_d.torqueTwo = parWrData;
            endcase
        end
        // measured results land in their register
        if (cal.wrValid) // R11
        begin
            case (cal.wrTarget)
                offset_cal_pkg::CMD_SPEED:  r_d.speedOne  = cal.wrValue; // R1
                offset_cal_pkg::CMD_TORQUE: r_d.torqueOne = cal.wrValue; // R1
                default:
                begin
                    r_d.hwValid  = 1'b1; // R3 R5
                    r_d.hwTarget = cal.wrTarget;
                    r_d.hwData   = cal.wrValue;
                end
            endcase
        end
        if (cal.done)
            r_d.cmd = offset_cal_pkg::CMD_RESET; // R11
        // restore only touches the idle command, never offsets
        if (restoreDefaults && !cal.busy && !cal.start)
            r_d.cmd = offset_cal_pkg::CMD_RESET; // R9
        if (parRead)
        begin
            case (parAddr)
                offset_cal_pkg::ADDR_CAL_CMD:    r_d.rdData = r_q.cmd;
                offset_cal_pkg::ADDR_SPEED_ONE:  r_d.rdData = r_q.speedOne;
                offset_cal_pkg::ADDR_SPEED_TWO:  r_d.rdData = r_q.speedTwo;
                offset_cal_pkg::ADDR_TORQUE_ONE: r_d.rdData = r_q.torqueOne;
                offset_cal_pkg::ADDR_TORQUE_TWO: r_d.rdData = r_q.torqueTwo;
                default:                         r_d.rdData = offset_cal_pkg::READ_UNMAPPED;
            endcase
        end
    end

    // state register
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            r_q           <= '0;
            r_q.cmd       <= offset_cal_pkg::CMD_RESET;
            r_q.speedOne  <= offset_cal_pkg::OFFSET_RESET;
            r_q.speedTwo  <= offset_cal_pkg::OFFSET_RESET;
            r_q.torqueOne <= offset_cal_pkg::OFFSET_RESET;
            r_q.torqueTwo <= offset_cal_pkg::OFFSET_RESET;
        end
        else
            r_q <= r_d;
    end

    // outputs
    assign parRdData      = r_q.rdData;
    assign parRefused     = r_q.refused;
    assign calBusy        = cal.busy;
    assign hwResultValid  = r_q.hwValid;
    assign hwResultTarget = r_q.hwTarget;
    assign hwResultData   = r_q.hwData;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_cmd_range;
        @(posedge sys_clk) disable iff (sys_rst)
        r_q.cmd <= offset_cal_pkg::CMD_MAX;
    endproperty
    a_cmd_range: assert property (p_cmd_range) else $error("command out of range"); // R2

    property p_bad_cmd;
        @(posedge sys_clk) disable iff (sys_rst)
        wrCmd && (parWrData == 16'h0000 || parWrData > 16'h0006)
            |-> !cal.start ##1 parRefused;
    endproperty
    a_bad_cmd: assert property (p_bad_cmd) else $error("bad command accepted"); // R2

    property p_disabled;
        @(posedge sys_clk) disable iff (sys_rst)
        !calEnable && parWrite |=> $stable(r_q.speedOne) && $stable(r_q.torqueTwo)
            && !cal.busy == !$past(cal.busy);
    endproperty
    a_disabled: assert property (p_disabled) else $error("write acted while disabled"); // R6

    property p_speed_store;
        @(posedge sys_clk) disable iff (sys_rst)
        cal.wrValid && cal.wrTarget == 3'h1 |=> r_q.speedOne == $past(cal.wrValue);
    endproperty
    a_speed_store: assert property (p_speed_store) else $error("speed result lost"); // R1

    property p_done_idle;
        @(posedge sys_clk) disable iff (sys_rst)
        cal.done |=> r_q.cmd == 16'h0000 && !calBusy;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("command not cleared"); // R11

    property p_offset_max;
        @(posedge sys_clk) disable iff (sys_rst)
        r_q.speedOne <= 16'h7FFF && r_q.speedTwo <= 16'h7FFF
            && r_q.torqueOne <= 16'h7FFF && r_q.torqueTwo <= 16'h7FFF;
    endproperty
    a_offset_max: assert property (p_offset_max) else $error("offset above limit"); // R8

    property p_restore_keeps;
        @(posedge sys_clk) disable iff (sys_rst)
        restoreDefaults && !parWrite && !cal.wrValid
            |=> $stable(r_q.speedOne) && $stable(r_q.speedTwo)
             && $stable(r_q.torqueOne) && $stable(r_q.torqueTwo);
    endproperty
    a_restore_keeps: assert property (p_restore_keeps) else $error("restore changed offset"); // R9

    property p_start_busy;
        @(posedge sys_clk) disable iff (sys_rst)
        cal.start |=> calBusy && r_q.cmd == $past(parWrData);
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start not taken"); // R4

    c_speed_cal: cover property (@(posedge sys_clk) cal.start && cal.cmd == 3'h1);
    c_igbt_done: cover property (@(posedge sys_clk) hwResultValid && hwResultTarget == 3'h6);
    c_refused:   cover property (@(posedge sys_clk) parRefused);
endmodule : offset_calibration_control

// ---- test/adc_partner.sv ----
// sample source model on the far side of the converter handshake
`timescale 1ns/10ps
module adc_partner (
    input  wire logic        sys_clk,    // bench clock
    input  wire logic        sys_rst,    // async reset, active high
    input  wire logic        adcReq,     // sample request from the block
    input  wire logic [2:0]  adcChannel, // item to sample
    input  wire logic [3:0]  ackDelay,   // request cycles before the answer, less one
    input  wire logic [15:0] sampleBase, // sample is base plus item code
    output logic             adcAck,     // sample ready, one cycle
    output logic [15:0]      adcData     // raw sample
);
    logic [3:0] waitCnt;
    logic       answered;

    ////////////////////////////////////////////////////////////////////////////
    // one answer per request after the chosen wait; data toggles when not valid
    always @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            waitCnt  <= 4'h0;
            answered <= 1'b0;
            adcAck   <= 1'b0;
            adcData  <= 16'hA5A5;
        end
        else
        begin
            adcAck  <= 1'b0;
            adcData <= ~adcData;
            if (!adcReq)
            begin
                waitCnt  <= 4'h0;
                answered <= 1'b0;
            end
            else if (!answered && waitCnt == ackDelay)
            begin
                adcAck   <= 1'b1;
                adcData  <= sampleBase + 16'(adcChannel);
                answered <= 1'b1;
            end
            else if (!answered)
                waitCnt <= waitCnt + 4'h1;
        end
    end
endmodule : adc_partner

// ---- test/test_offset_calibration_control.sv ----
// self-checking bench for the offset calibration control block
`timescale 1ns/10ps
module test_offset_calibration_control;
    logic        sys_clk = 1'b0, sys_rst = 1'b1;
    logic        parWrite = 1'b0, parRead = 1'b0, calEnable = 1'b0, restoreDefaults = 1'b0;
    logic [15:0] parAddr = 16'h0000, parWrData = 16'h0000, sampleBase = 16'h0000;
    logic [3:0]  ackDelay = 4'h0;
    logic [15:0] parRdData, adcData, hwResultData;
    logic        parRefused, adcReq, adcAck, calBusy, hwResultValid;
    logic [2:0]  adcChannel, hwResultTarget;
    int          err_total = 0, total_checks = 0;
    logic        running = 1'b0;
    logic [15:0] shadow [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    logic [15:0] addrTab [5] = '{offset_cal_pkg::ADDR_CAL_CMD, offset_cal_pkg::ADDR_SPEED_ONE,
        offset_cal_pkg::ADDR_SPEED_TWO, offset_cal_pkg::ADDR_TORQUE_ONE,
        offset_cal_pkg::ADDR_TORQUE_TWO};
    logic [2:0]  chanSeen [$];
    logic [18:0] hwSeen [$];

    offset_calibration_control i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .parWrite(parWrite), .parRead(parRead), .parAddr(parAddr), .parWrData(parWrData),
        .parRdData(parRdData), .parRefused(parRefused), .calEnable(calEnable),
        .restoreDefaults(restoreDefaults), .adcReq(adcReq), .adcChannel(adcChannel),
        .adcAck(adcAck), .adcData(adcData), .calBusy(calBusy), .hwResultValid(hwResultValid),
        .hwResultTarget(hwResultTarget), .hwResultData(hwResultData));
    adc_partner i_adc (.sys_clk(sys_clk), .sys_rst(sys_rst), .adcReq(adcReq),
        .adcChannel(adcChannel), .ackDelay(ackDelay), .sampleBase(sampleBase),
        .adcAck(adcAck), .adcData(adcData));

    ////////////////////////////////////////////////////////////////////////////
    // clock and result monitors
    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        if (adcAck === 1'b1 && adcReq === 1'b1)
            chanSeen.push_back(adcChannel);
        if (hwResultValid === 1'b1)
            hwSeen.push_back({hwResultTarget, hwResultData});
    end

    ////////////////////////////////////////////////////////////////////////////
    // expectation functions
    function automatic int slot(input logic [15:0] addr);
        for (int i = 0; i < 5; i++)
            if (addrTab[i] == addr)
                return i;
        return -1;
    endfunction : slot
    function automatic logic refuse(input logic [15:0] addr, input logic [15:0] data);
        if (addr == offset_cal_pkg::ADDR_CAL_CMD)
            return !calEnable || running || data == 16'h0000 || data > offset_cal_pkg::CMD_MAX;
        if (slot(addr) > 0)
            return !calEnable || data > offset_cal_pkg::OFFSET_MAX;
        return 1'b0;
    endfunction : refuse
    function automatic logic [15:0] clamp(input logic [15:0] x);
        return (x > offset_cal_pkg::OFFSET_MAX) ? offset_cal_pkg::OFFSET_MAX : x;
    endfunction : clamp

    ////////////////////////////////////////////////////////////////////////////
    // comparison, port access and closing tasks
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic access(input logic wr, input logic [15:0] addr, input logic [15:0] data);
        @(posedge sys_clk);
        parWrite  <= wr;
        parRead   <= !wr;
        parAddr   <= addr;
        parWrData <= data;
        @(posedge sys_clk);
        parWrite <= 1'b0;
        parRead  <= 1'b0;
        #1;
    endtask : access
    task automatic wr(input logic [15:0] addr, input logic [15:0] data);
        logic expRef;
        // enable taken at the strobe edge, so judge it after the access
        access(1'b1, addr, data);
        expRef = refuse(addr, data);
        check("parRefused", parRefused, expRef);
        if (!expRef && slot(addr) > 0)
            shadow[slot(addr)] = data;
    endtask : wr
    task automatic rdchk(input int idx);
        access(1'b0, addrTab[idx], 16'($urandom));
        check("parRdData", parRdData, shadow[idx]);
    endtask : rdchk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test

    ////////////////////////////////////////////////////////////////////////////
    // one calibration command from start to stored result
    task automatic run_cmd(input logic [2:0] cmd);
        int          n;
        logic [2:0]  ch;
        logic [15:0] v;
        logic [18:0] hwExp [$];
        ackDelay   <= 4'($urandom_range(0, 5));
        sampleBase <= (cmd == 3'h6) ? 16'hFFF0 : 16'($urandom);
        chanSeen.delete();
        hwSeen.delete();
        wr(offset_cal_pkg::ADDR_CAL_CMD, {13'h0000, cmd});
        check("calBusy", calBusy, 1'b1);
        running = 1'b1;
        wr(offset_cal_pkg::ADDR_CAL_CMD, 16'h0001);
        n = 0;
        while (calBusy === 1'b1 && n < 300)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        // last result pulse stands in the same cycle busy falls; the monitor takes it at the next edge
        @(posedge sys_clk);
        #1;
        running = 1'b0;
        check("busy bound", n < 300, 1'b1);
        n = (cmd == 3'h5) ? 4 : 1;
        check("sample count", chanSeen.size(), n);
        for (int i = 0; i < n; i++)
        begin
            ch = (cmd == 3'h5) ? 3'(i + 1) : cmd;
            v = clamp(sampleBase + 16'(ch));
            check("adcChannel", chanSeen[i], ch);
            if (ch == 3'h1)
                shadow[1] = v;
            else if (ch == 3'h2)
                shadow[3] = v;
            else
                hwExp.push_back({ch, v});
        end
        check("result count", hwSeen.size(), hwExp.size());
        foreach (hwExp[i])
            check("hwResult", hwSeen[i], hwExp[i]);
        for (int i = 0; i < 5; i++)
            rdchk(i);
        $display("test command %0d done", cmd);
    endtask : run_cmd

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        void'($urandom(32'h4d7e89df));
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 5; i++)
            rdchk(i);
        access(1'b0, 16'h0420, 16'h0000);
        check("unmapped", parRdData, offset_cal_pkg::READ_UNMAPPED);
        for (int i = 0; i < 5; i++)
            wr(addrTab[i], 16'h0005);
        for (int i = 0; i < 5; i++)
            rdchk(i);
        $display("test enable gate done");
        @(posedge sys_clk);
        calEnable <= 1'b1;
        wr(addrTab[1], 16'h7FFF);
        wr(addrTab[2], 16'h8000);
        wr(addrTab[3], 16'h0000);
        wr(addrTab[4], 16'hFFFF);
        // second offsets are touched only here, never around a calibration
        repeat (20)
            wr(addrTab[1 + ($urandom % 4)], 16'($urandom_range(0, 16'h9FFF)));
        for (int i = 0; i < 5; i++)
            rdchk(i);
        wr(addrTab[0], 16'h0000);
        wr(addrTab[0], 16'h0007);
        wr(addrTab[0], 16'($urandom_range(7, 16'hFFFF)));
        rdchk(0);
        $display("test manual writes done");
        for (int c = 1; c <= 6; c++)
            run_cmd(3'(c));
        run_cmd(3'h5);
        @(posedge sys_clk);
        restoreDefaults <= 1'b1;
        @(posedge sys_clk);
        restoreDefaults <= 1'b0;
        for (int i = 0; i < 5; i++)
            rdchk(i);
        $display("test restore defaults done");
        stop_test;
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog well beyond the expected run of a few hundred cycles
    initial
    begin
        #200000;
        err_total++;
        $display("watchdog expired");
        stop_test;
    end
endmodule : test_offset_calibration_control
